// [fp_dispatch_pkg.sv]
package fp_dispatch_pkg;

    localparam int SPEC_W = 5;
    localparam int WORD_W = 32;
    localparam int OPND_W = 96;
    localparam int NUM_REGS = 32;
    localparam int TEXC_W = 5;
    localparam int TFCC_W = 2;

    // Sign handling for the single-precision moves
    localparam logic [31:0] SIGN_FLIP_MASK = 32'h8000_0000;
    localparam logic [31:0] SIGN_CLEAR_MASK = 32'h7fff_ffff;
    localparam logic [4:0] TEXC_NONE = 5'h00;
    localparam logic [1:0] TFCC_RESET = 2'h0;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {PREC_S = 2'h0, PREC_D = 2'h1, PREC_X = 2'h2} prec_t;

    typedef enum logic [5:0] {
        OP_INT_TO_SINGLE = 6'h00, OP_INT_TO_DOUBLE = 6'h01, OP_INT_TO_EXT = 6'h02,
        OP_SINGLE_TO_INT = 6'h03, OP_DOUBLE_TO_INT = 6'h04, OP_EXT_TO_INT = 6'h05,
        OP_S_TO_D = 6'h06, OP_S_TO_X = 6'h07, OP_D_TO_S = 6'h08,
        OP_D_TO_X = 6'h09, OP_X_TO_S = 6'h0a, OP_X_TO_D = 6'h0b,
        OP_MOVE_SINGLE = 6'h0c, OP_NEGATE_SINGLE = 6'h0d, OP_ABSOLUTE_SINGLE = 6'h0e,
        OP_SQRT_S = 6'h0f, OP_SQRT_D = 6'h10, OP_SQRT_X = 6'h11,
        OP_ADD_S = 6'h12, OP_ADD_D = 6'h13, OP_ADD_X = 6'h14,
        OP_SUB_S = 6'h15, OP_SUB_D = 6'h16, OP_SUB_X = 6'h17,
        OP_MUL_S = 6'h18, OP_MUL_D = 6'h19, OP_MUL_X = 6'h1a,
        OP_DIV_S = 6'h1b, OP_DIV_D = 6'h1c, OP_DIV_X = 6'h1d,
        OP_CMP_S = 6'h1e, OP_CMP_D = 6'h1f, OP_CMP_X = 6'h20,
        OP_SCMP_S = 6'h21, OP_SCMP_D = 6'h22, OP_SCMP_X = 6'h23
    } fp_op_t;

    typedef struct packed {
        prec_t src;
        prec_t dst;
        logic dyadic;
        logic cmp;
        logic local_op;
    } op_info_t;

    typedef struct packed {
        logic valid;
        fp_op_t func;
        logic [OPND_W-1:0] opa;
        logic [OPND_W-1:0] opb;
    } unit_req_t;

    typedef struct packed {
        logic done;
        logic [OPND_W-1:0] result;
        logic [TEXC_W-1:0] texc;
        logic [TFCC_W-1:0] tfcc;
        logic complete;
    } unit_resp_t;

    // Aligned pair member: bits 4..1 of the specifier, low bit chooses even or odd
    function automatic logic [4:0] pair_reg(input logic [4:0] spec, input logic odd);
        return {spec[4:1], odd};
    endfunction

    // Aligned triple member: bits 4..2 of the specifier with 00, 01 or 10 below
    function automatic logic [4:0] triple_reg(input logic [4:0] spec, input logic [1:0] lo);
        return {spec[4:2], lo};
    endfunction

    // Operand shapes and routing per operation
    function automatic op_info_t decode_op(input fp_op_t op);
        op_info_t info;
        info.src = PREC_S;
        info.dst = PREC_S;
        if (op inside {OP_DOUBLE_TO_INT, OP_D_TO_S, OP_D_TO_X, OP_SQRT_D, OP_ADD_D, OP_SUB_D,
                       OP_MUL_D, OP_DIV_D, OP_CMP_D, OP_SCMP_D})
            info.src = PREC_D;
        if (op inside {OP_EXT_TO_INT, OP_X_TO_S, OP_X_TO_D, OP_SQRT_X, OP_ADD_X, OP_SUB_X,
                       OP_MUL_X, OP_DIV_X, OP_CMP_X, OP_SCMP_X})
            info.src = PREC_X;
        if (op inside {OP_INT_TO_DOUBLE, OP_S_TO_D, OP_X_TO_D, OP_SQRT_D, OP_ADD_D, OP_SUB_D,
                       OP_MUL_D, OP_DIV_D})
            info.dst = PREC_D;
        if (op inside {OP_INT_TO_EXT, OP_S_TO_X, OP_D_TO_X, OP_SQRT_X, OP_ADD_X, OP_SUB_X,
                       OP_MUL_X, OP_DIV_X})
            info.dst = PREC_X;
        info.dyadic = (op >= OP_ADD_S);
        info.cmp = (op >= OP_CMP_S);
        info.local_op = op inside {OP_MOVE_SINGLE, OP_NEGATE_SINGLE, OP_ABSOLUTE_SINGLE};
        return info;
    endfunction

endpackage

// [fp_operand_gather.sv]
`timescale 1ns/1ns
// Builds one left-justified 96-bit operand from the register file
module fp_operand_gather
    import fp_dispatch_pkg::*;
(
    input wire logic [NUM_REGS-1:0][WORD_W-1:0] regs_i,
    input wire logic [SPEC_W-1:0] spec_i,
    input wire prec_t prec_i,
    input wire logic use_i,
    output logic [OPND_W-1:0] opnd_o
);

    logic [WORD_W-1:0] single_w;
    logic [WORD_W-1:0] even_w;
    logic [WORD_W-1:0] odd_w;
    logic [WORD_W-1:0] ext0_w;
    logic [WORD_W-1:0] ext1_w;
    logic [WORD_W-1:0] ext2_w;

    // Register selection for each shape
    assign single_w = regs_i[spec_i];
    assign even_w = regs_i[pair_reg(spec_i, 1'b0)];
    assign odd_w = regs_i[pair_reg(spec_i, 1'b1)];
    assign ext0_w = regs_i[triple_reg(spec_i, 2'h0)];
    assign ext1_w = regs_i[triple_reg(spec_i, 2'h1)];
    assign ext2_w = regs_i[triple_reg(spec_i, 2'h2)];

    // Unused operands read as zero so a unit never sees stale data
    assign opnd_o = !use_i ? '0 :
                    (prec_i == PREC_X) ? {ext0_w, ext1_w, ext2_w} :
                    (prec_i == PREC_D) ? {even_w, odd_w, 32'h0000_0000} :
                    {single_w, 64'h0000_0000_0000_0000};

endmodule // fp_operand_gather

// [fp_operate_dispatch.sv]
`timescale 1ns/1ns
// How it works
// - A double operand uses the even register from specifier bits 4..1 plus 0 and the odd one plus 1.
// - An extended operand uses specifier bits 4..2 with 00, 01 and 10 appended, joined in that order.
// - Every arithmetic or conversion answer carries a 5-bit trial exception vector.
// - Compares answer with a 2-bit trial condition code instead of a numeric result.
// - Every answer carries a completion flag saying whether the unit could finish.
// - Integer-to-float conversions read one single register named by the second specifier.
// - Float-to-integer reads one register, an aligned pair or an aligned triple by source precision.
// - Format conversions read the source as one, two or three aligned registers by source precision.
// - Single negate returns the source with bit 31 flipped by an exclusive-OR mask.
// - Single absolute value clears bit 31 by an AND mask, and the plain move passes the source.
// - Move, negate and absolute value report a zero exception vector and completion of one.
// - Square roots use only the second operand, shaped by precision.
// - Add and subtract take both operands in the chosen shape, subtract being first minus second.
// - Multiply and divide take both operands, divide using the first as dividend.
// - Ordinary compares take both operands and return code, exception vector and completion.
// - Signalling compares exist per precision with their own function code and the same answers.
module fp_operate_dispatch
    import fp_dispatch_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic ISSUE_VALID_I,
    input wire fp_op_t ISSUE_OP_I,
    input wire logic [SPEC_W-1:0] ISSUE_RS1_I,
    input wire logic [SPEC_W-1:0] ISSUE_RS2_I,
    input wire logic [SPEC_W-1:0] ISSUE_RD_I,
    output logic ISSUE_READY_O,
    input wire logic LOAD_WE_I,
    input wire logic [SPEC_W-1:0] LOAD_IDX_I,
    input wire logic [WORD_W-1:0] LOAD_DATA_I,
    input wire logic [SPEC_W-1:0] STORE_IDX_I,
    output logic [WORD_W-1:0] STORE_DATA_O,
    output unit_req_t UNIT_REQ_O,
    input wire unit_resp_t UNIT_RESP_I,
    output logic DONE_O,
    output logic [OPND_W-1:0] RESULT_O,
    output logic [TEXC_W-1:0] TEXC_O,
    output logic [TFCC_W-1:0] TFCC_O,
    output logic COMPLETE_O,
    output logic CMP_O
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_UNIT = 3'h2,
        ST_FINISH = 3'h4
    } state_t;

    state_t state_r;
    state_t state_nxt;
    logic [NUM_REGS-1:0][WORD_W-1:0] regs_r;
    logic [NUM_REGS-1:0][WORD_W-1:0] wb_data;
    logic [NUM_REGS-1:0] wb_we;
    op_info_t info;
    op_info_t req_info;
    logic accept;
    logic unit_ans;
    logic [OPND_W-1:0] opa_w;
    logic [OPND_W-1:0] opb_w;
    logic [WORD_W-1:0] src1_word;
    logic [WORD_W-1:0] src2_word;
    logic [WORD_W-1:0] local_word;
    logic [SPEC_W-1:0] rd_r;
    prec_t dst_r;
    unit_req_t req_r;
    logic ready_r;
    logic [WORD_W-1:0] store_r;
    logic done_r;
    logic [OPND_W-1:0] res_r;
    logic [TEXC_W-1:0] texc_r;
    logic [TFCC_W-1:0] tfcc_r;
    logic comp_r;
    logic cmp_r;

    // Decode and handshake qualifiers
    assign info = decode_op(ISSUE_OP_I);
    assign req_info = decode_op(req_r.func);
    assign accept = ISSUE_VALID_I && (state_r == ST_IDLE);
    assign unit_ans = req_r.valid && UNIT_RESP_I.done;
    assign src1_word = regs_r[ISSUE_RS1_I];
    assign src2_word = regs_r[ISSUE_RS2_I];

    // First source only for two-operand work, so square roots see a zero first operand
    fp_operand_gather gather_a (
        .regs_i(regs_r),
        .spec_i(ISSUE_RS1_I),
        .prec_i(info.src),
        .use_i(info.dyadic),
        .opnd_o(opa_w)
    );

    // Second source is always used; its shape follows the source precision
    fp_operand_gather gather_b (
        .regs_i(regs_r),
        .spec_i(ISSUE_RS2_I),
        .prec_i(info.src),
        .opnd_o(opb_w),
        .use_i(1'b1)
    );

    // Moves are done here, they are too cheap to spend a unit round trip on
    assign local_word = (ISSUE_OP_I == OP_NEGATE_SINGLE) ? (opb_w[95:64] ^ SIGN_FLIP_MASK) :
                        (ISSUE_OP_I == OP_ABSOLUTE_SINGLE) ? (opb_w[95:64] & SIGN_CLEAR_MASK) :
                        opb_w[95:64];

    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (accept)
                    state_nxt = info.local_op ? ST_FINISH : ST_UNIT;
            end
            ST_UNIT:
            begin
                if (UNIT_RESP_I.done)
                    state_nxt = ST_FINISH;
            end
            ST_FINISH:
            begin
                state_nxt = ST_IDLE;
            end
            // Non one-hot codes, and the unknown state before reset, fall back to idle
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Ready only while idle; issue attempts at other times are ignored
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
            ready_r <= 1'b0;
        else
            ready_r <= (state_nxt == ST_IDLE);
    end

    // Destination captured at issue for the write-back
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            rd_r <= '0;
            dst_r <= PREC_S;
        end
        else if (accept)
        begin
            rd_r <= ISSUE_RD_I;
            dst_r <= info.dst;
        end
    end

    // Unit request holds steady until the unit answers with done
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
            req_r <= '0;
        else if (accept && !info.local_op)
        begin
            req_r.valid <= 1'b1;
            req_r.func <= ISSUE_OP_I;
            req_r.opa <= opa_w;
            req_r.opb <= opb_w;
        end
        else if (unit_ans)
            req_r.valid <= 1'b0;
    end

    // Answer capture: local moves or the unit's four outputs
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            done_r <= 1'b0;
            res_r <= '0;
            texc_r <= TEXC_NONE;
            tfcc_r <= TFCC_RESET;
            comp_r <= 1'b0;
            cmp_r <= 1'b0;
        end
        else
        begin
            done_r <= (accept && info.local_op) || unit_ans;
            if (accept && info.local_op)
            begin
                res_r <= {local_word, 64'h0000_0000_0000_0000};
                texc_r <= TEXC_NONE;
                tfcc_r <= TFCC_RESET;
                comp_r <= 1'b1;
                cmp_r <= 1'b0;
            end
            else if (unit_ans)
            begin
                res_r <= UNIT_RESP_I.result;
                texc_r <= UNIT_RESP_I.texc;
                tfcc_r <= UNIT_RESP_I.tfcc;
                comp_r <= UNIT_RESP_I.complete;
                cmp_r <= req_info.cmp;
            end
        end
    end

    // Write-back: a compare or an unfinished operation leaves the file alone
    always_comb
    begin
        wb_we = '0;
        wb_data = '0;
        if ((state_r == ST_FINISH) && comp_r && !cmp_r)
        begin
            unique case (dst_r)
                PREC_S:
                begin
                    wb_we[rd_r] = 1'b1;
                    wb_data[rd_r] = res_r[95:64];
                end
                PREC_D:
                begin
                    wb_we[pair_reg(rd_r, 1'b0)] = 1'b1;
                    wb_data[pair_reg(rd_r, 1'b0)] = res_r[95:64];
                    wb_we[pair_reg(rd_r, 1'b1)] = 1'b1;
                    wb_data[pair_reg(rd_r, 1'b1)] = res_r[63:32];
                end
                PREC_X:
                begin
                    wb_we[triple_reg(rd_r, 2'h0)] = 1'b1;
                    wb_data[triple_reg(rd_r, 2'h0)] = res_r[95:64];
                    wb_we[triple_reg(rd_r, 2'h1)] = 1'b1;
                    wb_data[triple_reg(rd_r, 2'h1)] = res_r[63:32];
                    wb_we[triple_reg(rd_r, 2'h2)] = 1'b1;
                    wb_data[triple_reg(rd_r, 2'h2)] = res_r[31:0];
                end
                default:
                begin
                    wb_we = '0;
                end
            endcase
        end
    end

    // Register file; a result write beats a memory load to the same register
    always_ff @(posedge REF_CLK_I)
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (!RST_N_I)
                regs_r[i] <= REG_RESET;
            else if (wb_we[i])
                regs_r[i] <= wb_data[i];
            else if (LOAD_WE_I && (LOAD_IDX_I == SPEC_W'(i)))
                regs_r[i] <= LOAD_DATA_I;
        end
    end

    // Store read port, one cycle behind its index
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
            store_r <= REG_RESET;
        else
            store_r <= regs_r[STORE_IDX_I];
    end

    // Outputs straight from flops
    assign ISSUE_READY_O = ready_r;
    assign STORE_DATA_O = store_r;
    assign UNIT_REQ_O = req_r;
    assign DONE_O = done_r;
    assign RESULT_O = res_r;
    assign TEXC_O = texc_r;
    assign TFCC_O = tfcc_r;
    assign COMPLETE_O = comp_r;
    assign CMP_O = cmp_r;

    // Helper words that the checks below compare against
    logic [WORD_W-1:0] even2_w;
    logic [WORD_W-1:0] odd2_w;
    logic [WORD_W-1:0] ext20_w;
    logic [WORD_W-1:0] ext21_w;
    logic [WORD_W-1:0] ext22_w;
    assign even2_w = regs_r[{ISSUE_RS2_I[4:1], 1'b0}];
    assign odd2_w = regs_r[{ISSUE_RS2_I[4:1], 1'b1}];
    assign ext20_w = regs_r[{ISSUE_RS2_I[4:2], 2'b00}];
    assign ext21_w = regs_r[{ISSUE_RS2_I[4:2], 2'b01}];
    assign ext22_w = regs_r[{ISSUE_RS2_I[4:2], 2'b10}];

    default clocking chk_cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    local_done_a: assert property (
        accept && info.local_op |=> DONE_O && (TEXC_O == TEXC_NONE) && COMPLETE_O && !UNIT_REQ_O.valid)
        else $error("move family answer not clean");

    negate_bit_a: assert property (
        accept && (ISSUE_OP_I == OP_NEGATE_SINGLE) |=> RESULT_O[95:64] == ($past(src2_word) ^ SIGN_FLIP_MASK))
        else $error("negate did not flip the sign bit");

    abs_bit_a: assert property (
        accept && (ISSUE_OP_I == OP_ABSOLUTE_SINGLE) |=> RESULT_O[95:64] == ($past(src2_word) & SIGN_CLEAR_MASK))
        else $error("absolute value did not clear the sign bit");

    pair_align_a: assert property (
        accept && (info.src == PREC_D) |=> UNIT_REQ_O.opb[95:32] == {$past(even2_w), $past(odd2_w)})
        else $error("double operand pair misaligned");

    triple_align_a: assert property (
        accept && (info.src == PREC_X) |=> UNIT_REQ_O.opb == {$past(ext20_w), $past(ext21_w), $past(ext22_w)})
        else $error("extended operand triple misaligned");

    sqrt_monadic_a: assert property (
        UNIT_REQ_O.valid && (UNIT_REQ_O.func inside {OP_SQRT_S, OP_SQRT_D, OP_SQRT_X}) |-> UNIT_REQ_O.opa == '0)
        else $error("square root carried a first operand");

    int_source_a: assert property (
        accept && (ISSUE_OP_I inside {OP_INT_TO_SINGLE, OP_INT_TO_DOUBLE, OP_INT_TO_EXT})
        |=> UNIT_REQ_O.opb == {$past(src2_word), 64'h0000_0000_0000_0000})
        else $error("integer source not a single register");

    operand_order_a: assert property (
        accept && (ISSUE_OP_I inside {OP_SUB_S, OP_DIV_S})
        |=> (UNIT_REQ_O.opa[95:64] == $past(src1_word)) && (UNIT_REQ_O.opb[95:64] == $past(src2_word)))
        else $error("first and second operands swapped");

    req_hold_a: assert property (
        UNIT_REQ_O.valid && !UNIT_RESP_I.done |=> UNIT_REQ_O.valid && $stable(UNIT_REQ_O))
        else $error("unit request dropped before done");

    answer_take_a: assert property (
        unit_ans |=> DONE_O && !UNIT_REQ_O.valid && (TEXC_O == $past(UNIT_RESP_I.texc))
        && (COMPLETE_O == $past(UNIT_RESP_I.complete)) ##1 ISSUE_READY_O)
        else $error("unit answer not passed on");

    cmp_code_a: assert property (
        unit_ans && (req_r.func inside {OP_CMP_S, OP_CMP_D, OP_CMP_X, OP_SCMP_S, OP_SCMP_D, OP_SCMP_X})
        |=> CMP_O && (TFCC_O == $past(UNIT_RESP_I.tfcc)))
        else $error("compare code not returned");

endmodule // fp_operate_dispatch

// [fp_unit_model.sv]
`timescale 1ns/1ns
// Far-side arithmetic unit: answers each request once, promptly or after a stall
module fp_unit_model
    import fp_dispatch_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire unit_req_t req_i,
    input wire logic slow_i,
    input wire logic fail_i,
    output unit_resp_t resp_o
);
    logic [2:0] cnt_r;
    logic sent_r;

    // Answer fields toggle while idle so a late sample never sees stale data
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            resp_o <= '0;
            cnt_r <= 3'h0;
            sent_r <= 1'h0;
        end
        else
        begin
            resp_o.done <= 1'h0;
            resp_o.result <= ~resp_o.result;
            resp_o.texc <= ~resp_o.texc;
            resp_o.tfcc <= ~resp_o.tfcc;
            resp_o.complete <= ~resp_o.complete;
            if (req_i.valid && !sent_r)
            begin
                if (cnt_r >= (slow_i ? 3'h4 : 3'h0))
                begin
                    resp_o.done <= 1'h1;
                    resp_o.result <= req_i.opa ^ {req_i.opb[0], req_i.opb[95:1]};
                    resp_o.texc <= req_i.func[4:0];
                    resp_o.tfcc <= req_i.func[1:0];
                    resp_o.complete <= !fail_i;
                    sent_r <= 1'h1;
                    cnt_r <= 3'h0;
                end
                else
                    cnt_r <= cnt_r + 3'h1;
            end
            else if (!req_i.valid)
                sent_r <= 1'h0;
        end
    end
endmodule // fp_unit_model

// [fp_operate_dispatch_bench.sv]
`timescale 1ns/1ns
module fp_operate_dispatch_bench
    import fp_dispatch_pkg::*;
;
    typedef struct packed {logic [95:0] r; logic [4:0] e; logic [1:0] f; logic c; logic k;} exp_t;
    logic clk = 0, rst_n = 0, iv = 0, lwe = 0, slow = 0, fail = 0;
    fp_op_t op = OP_MOVE_SINGLE;
    logic [4:0] rs1 = 0, rs2 = 0, rd = 0, lidx = 0, sidx = 0;
    logic [31:0] ldata = 0;
    logic ready, done, complete, cmp;
    logic [31:0] sdata;
    logic [95:0] res;
    logic [4:0] texc;
    logic [1:0] tfcc;
    unit_req_t req;
    unit_resp_t resp;
    int bad_count = 0, total_checks = 0;
    logic [31:0] m [32];
    logic [3:0] tbl [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9};
    exp_t q[$];

    // Free-running 100 MHz clock
    initial forever #5 clk = ~clk;

    fp_operate_dispatch u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .ISSUE_VALID_I(iv), .ISSUE_OP_I(op),
        .ISSUE_RS1_I(rs1), .ISSUE_RS2_I(rs2), .ISSUE_RD_I(rd), .ISSUE_READY_O(ready),
        .LOAD_WE_I(lwe), .LOAD_IDX_I(lidx), .LOAD_DATA_I(ldata), .STORE_IDX_I(sidx),
        .STORE_DATA_O(sdata), .UNIT_REQ_O(req), .UNIT_RESP_I(resp), .DONE_O(done), .RESULT_O(res),
        .TEXC_O(texc), .TFCC_O(tfcc), .COMPLETE_O(complete), .CMP_O(cmp));
    fp_unit_model u_unit (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .slow_i(slow), .fail_i(fail),
        .resp_o(resp));

    task automatic fail_msg(string s);
        bad_count++;
        $display("CHECK FAILED at %0t: %s", $time, s);
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Own model of the aligned register groups, left-justified and zero-filled
    function automatic logic [95:0] gat(logic [4:0] s, logic [1:0] p);
        case (p)
            2'h0: return {m[s], 64'h0};
            2'h1: return {m[{s[4:1], 1'h0}], m[{s[4:1], 1'h1}], 32'h0};
            default: return {m[{s[4:2], 2'h0}], m[{s[4:2], 2'h1}], m[{s[4:2], 2'h2}]};
        endcase
    endfunction

    // Source and target precision packed as {src, dst}
    function automatic logic [3:0] precs(int v);
        if (v < 3) return {2'h0, 2'(v)};
        if (v < 6) return {2'(v - 3), 2'h0};
        if (v < 12) return tbl[v - 6];
        if (v < 15) return 4'h0;
        return {2'((v - 15) % 3), 2'((v - 15) % 3)};
    endfunction

    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge clk);
        while (ready !== 1'h1)
        begin
            if (++n > 60)
            begin
                fail_msg("ready never returned");
                finish_test();
            end
            @(negedge clk);
        end
    endtask

    // Predict, issue, and during a stall try an issue that must be ignored
    task automatic run_op(int o, logic sl);
        logic [4:0] s1, s2, d;
        logic [3:0] pp;
        logic [95:0] a, b;
        exp_t x;
        s1 = 5'($urandom);
        s2 = 5'($urandom);
        d = 5'($urandom);
        pp = precs(o);
        a = (o >= 18) ? gat(s1, pp[3:2]) : 96'h0;
        b = gat(s2, pp[3:2]);
        x.k = (o >= 30);
        x.f = 2'(o);
        if (o >= 12 && o <= 14)
        begin
            x.r = {(o == 12) ? m[s2] : (o == 13) ? m[s2] ^ 32'h8000_0000 : m[s2] & 32'h7fff_ffff, 64'h0};
            x.e = 5'h00;
            x.c = 1'h1;
        end
        else
        begin
            x.r = a ^ {b[0], b[95:1]};
            x.e = 5'(o);
            x.c = !(sl && ($urandom % 4 == 0));
        end
        wait_ready();
        q.push_back(x);
        @(posedge clk);
        iv <= 1;
        op <= fp_op_t'(o);
        rs1 <= s1;
        rs2 <= s2;
        rd <= d;
        slow <= sl;
        fail <= !x.c;
        @(posedge clk);
        if (sl && !(o >= 12 && o <= 14))
        begin
            op <= OP_NEGATE_SINGLE;
            @(posedge clk);
        end
        iv <= 0;
        if (x.c && !x.k)
            case (pp[1:0])
                2'h0: m[d] = x.r[95:64];
                2'h1: {m[{d[4:1], 1'h0}], m[{d[4:1], 1'h1}]} = x.r[95:32];
                default: {m[{d[4:2], 2'h0}], m[{d[4:2], 2'h1}], m[{d[4:2], 2'h2}]} = x.r;
            endcase
        wait_ready();
    endtask

    // Each answer is matched against the oldest prediction
    always @(negedge clk)
    begin
        exp_t x;
        if (done === 1'h1)
        begin
            total_checks++;
            if (q.size() == 0)
                fail_msg("answer with no issue");
            else
            begin
                x = q.pop_front();
                if (x.k ? tfcc !== x.f : res !== x.r)
                    fail_msg("result or condition code");
                if (texc !== x.e || complete !== x.c || cmp !== x.k)
                    fail_msg("exception vector, completion or kind");
            end
        end
    end

    // Main sequence
    initial
    begin
        void'($urandom(52947));
        repeat (12) @(posedge clk);
        rst_n <= 1;
        wait_ready();
        total_checks++;
        if (done !== 1'h0)
            fail_msg("answer after reset");
        for (int i = 0; i < 32; i++)
        begin
            @(posedge clk);
            m[i] = $urandom;
            lwe <= 1;
            lidx <= 5'(i);
            ldata <= m[i];
        end
        @(posedge clk);
        lwe <= 0;
        // Every operation, first with a prompt unit, then stalled with random failures
        for (int p = 0; p < 2; p++)
            for (int o = 0; o <= 35; o++)
                run_op(o, p[0]);
        // Write-backs seen through the store port
        for (int i = 0; i < 32; i++)
        begin
            @(posedge clk);
            sidx <= 5'(i);
            @(posedge clk);
            @(negedge clk);
            total_checks++;
            if (sdata !== m[i])
                fail_msg("register contents");
        end
        total_checks++;
        if (q.size() != 0)
            fail_msg("missing answers");
        // Mid-run reset must clear the answer fields, the request and register 31 as read at the store port
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        wait_ready();
        total_checks++;
        if (done !== 1'h0 || res !== 96'h0 || texc !== 5'h00 || complete !== 1'h0 || cmp !== 1'h0)
            fail_msg("answer fields after reset");
        total_checks++;
        if (tfcc !== 2'h0 || req.valid !== 1'h0 || sdata !== 32'h0)
            fail_msg("request, code or register after reset");
        finish_test();
    end
endmodule // fp_operate_dispatch_bench
